//--- logic/svf_map.svh
`ifndef SVF_MAP_SVH
`define SVF_MAP_SVH
// Contract
// - One channel pair reaches the modulator
// - Select codes map to four input pairs
// - Polarity and gain set the input span
// - Single variant: unipolar, gain one only
// - Rate spans 0.05 to 0.45 clock
// - Pulses fixed width, only rate varies
// - Pulse lasts one whole clock period
// - Pulse starts on a clock edge
// - Output invalid until settling elapses
// - Modulator samples input every clock
// - Comparator drives one-bit feedback every clock
// - Power-down low halts conversion

// Analog codes and reference are unsigned sample words
`define SVF_CODE_W 12
// Integrator word width, covers threshold plus one step
`define SVF_ACC_W 19
// Charge per clock is REF*2 + 8*num; balance point is 40*REF
`define SVF_OFFSET_MUL 2
`define SVF_SLOPE_SHIFT 3
`define SVF_THRESH_MUL 40
// Settling in master clock cycles per variant
`define SVF_SETTLE_MULTI 4'h2
`define SVF_SETTLE_SINGLE 4'ha
// Channel select codes
`define SVF_SEL_1_4 2'h0
`define SVF_SEL_2_4 2'h1
`define SVF_SEL_3_4 2'h2
`define SVF_SEL_1_2 2'h3
`endif

//--- logic/svf_pkg.sv
package svf_pkg;
  `include "svf_map.svh"

  // Pin strapped controls
  typedef struct packed {
    logic single_variant;
    logic channel_select_hi;
    logic channel_select_lo;
    logic polarity_select;
    logic gain_select;
  } svf_cfg_t;

  // The four buffered inputs, sampled as codes
  typedef struct packed {
    logic [`SVF_CODE_W-1:0] analog_input_one;
    logic [`SVF_CODE_W-1:0] analog_input_two;
    logic [`SVF_CODE_W-1:0] analog_input_three;
    logic [`SVF_CODE_W-1:0] analog_input_common;
  } svf_ain_t;

  typedef enum logic [2:0] {
    SVF_HALT = 3'h1,
    SVF_SETTLE = 3'h2,
    SVF_RUN = 3'h4
  } svf_state_t;

  typedef struct packed {
    svf_state_t state;
    logic [`SVF_ACC_W-1:0] acc;
    logic [3:0] settle_cnt;
    svf_cfg_t cfg_prev;
    logic freq_out;
    logic freq_valid;
  } svf_regs_t;
endpackage

//--- logic/svf_converter.sv
`timescale 1ns/100ps
`include "svf_map.svh"
module svf_converter (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Straps and power control
  input wire svf_pkg::svf_cfg_t CFG,
  input wire logic POWER_DOWN_N,
  // Analog side as codes
  input wire svf_pkg::svf_ain_t AIN,
  input wire logic [11:0] REF_LEVEL,
  // Pulse train
  output logic FREQ_OUT,
  output logic FREQ_VALID
);
  import svf_pkg::*;

  svf_regs_t r;
  svf_regs_t next_r;
  logic [11:0] pos;
  logic [11:0] neg;
  logic signed [15:0] diff;
  logic signed [15:0] scaled;
  logic signed [15:0] span;
  logic [15:0] num;
  logic [`SVF_ACC_W-1:0] charge;
  logic [`SVF_ACC_W-1:0] thresh;
  logic [`SVF_ACC_W-1:0] sum;
  logic bipolar;
  logic gain_two;
  logic [3:0] settle_len;

  // Differential multiplexer: exactly one pair reaches the modulator
  always_comb begin
    pos = AIN.analog_input_one;
    neg = AIN.analog_input_common;
    if (CFG.single_variant) begin
      neg = 12'h000; // Single-ended against ground
    end else begin
      unique case ({CFG.channel_select_hi, CFG.channel_select_lo})
        `SVF_SEL_1_4: begin
          pos = AIN.analog_input_one;
          neg = AIN.analog_input_common;
        end
        `SVF_SEL_2_4: begin
          pos = AIN.analog_input_two;
          neg = AIN.analog_input_common;
        end
        `SVF_SEL_3_4: begin
          pos = AIN.analog_input_three;
          neg = AIN.analog_input_common;
        end
        `SVF_SEL_1_2: begin
          pos = AIN.analog_input_one;
          neg = AIN.analog_input_two;
        end
      endcase
    end
  end

  // Span selection; single variant ignores polarity and gain straps
  assign bipolar = ~CFG.single_variant & ~CFG.polarity_select;
  assign gain_two = ~CFG.single_variant & CFG.gain_select;
  assign settle_len = CFG.single_variant ? `SVF_SETTLE_SINGLE : `SVF_SETTLE_MULTI;

  // Map input to a fraction num/(2*REF), clamped to the span ends
  always_comb begin
    diff = $signed({4'h0, pos}) - $signed({4'h0, neg});
    span = $signed({3'h0, REF_LEVEL, 1'b0});
    if (bipolar) begin
      scaled = (gain_two ? (diff <<< 1) : diff) + $signed({4'h0, REF_LEVEL});
    end else begin
      scaled = gain_two ? (diff <<< 2) : (diff <<< 1);
    end
    if (scaled < 16'sh0000) begin
      num = 16'h0000;
    end else if (scaled > span) begin
      num = 16'(span);
    end else begin
      num = 16'(scaled);
    end
  end

  // Charge per clock gives a rate of (1 + 8x)/20 of the clock
  assign charge = `SVF_ACC_W'({REF_LEVEL, 1'b0}) * `SVF_ACC_W'(`SVF_OFFSET_MUL / 2)
    + (`SVF_ACC_W'(num) << `SVF_SLOPE_SHIFT);
  assign thresh = `SVF_ACC_W'(REF_LEVEL) * `SVF_ACC_W'(`SVF_THRESH_MUL);
  assign sum = r.acc + charge;

  // Next state
  always_comb begin
    next_r = r;
    next_r.cfg_prev = CFG;
    next_r.freq_out = 1'b0;
    if (!POWER_DOWN_N) begin
      next_r.state = SVF_HALT;
      next_r.acc = '0;
      next_r.freq_valid = 1'b0;
      next_r.settle_cnt = 4'h0;
    end else begin
      // Integrate every clock; comparator bit removes one reference quantum
      if (sum >= thresh) begin
        next_r.acc = sum - thresh;
        next_r.freq_out = 1'b1; // One-cycle pulse launched by this edge
      end else begin
        next_r.acc = sum;
      end
      unique case (r.state)
        SVF_HALT: begin
          next_r.state = SVF_SETTLE; // Wake-up counts as power-up
          next_r.settle_cnt = 4'h0;
          next_r.freq_valid = 1'b0;
        end
        SVF_SETTLE: begin
          if (CFG != r.cfg_prev) begin
            next_r.settle_cnt = 4'h0;
          end else if (r.settle_cnt + 4'h1 >= settle_len) begin
            next_r.state = SVF_RUN;
            next_r.freq_valid = 1'b1;
          end else begin
            next_r.settle_cnt = r.settle_cnt + 4'h1;
          end
        end
        SVF_RUN: begin
          if (CFG != r.cfg_prev) begin
            next_r.state = SVF_SETTLE;
            next_r.settle_cnt = 4'h0;
            next_r.freq_valid = 1'b0;
          end
        end
        default: begin
          next_r.state = SVF_HALT;
          next_r.freq_valid = 1'b0;
        end
      endcase
    end
  end

  // State register; pulse is a whole clock since outputs must be registered
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      r <= '{state: SVF_HALT, acc: '0, settle_cnt: 4'h0, cfg_prev: '0, freq_out: 1'b0, freq_valid: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign FREQ_OUT = r.freq_out;
  assign FREQ_VALID = r.freq_valid;
endmodule

//--- tb/svf_converter_properties.sv
`timescale 1ns/100ps
module svf_converter_properties (
  // Watched ports
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire svf_pkg::svf_cfg_t CFG,
  input wire logic POWER_DOWN_N,
  input wire logic FREQ_OUT,
  input wire logic FREQ_VALID
);
  import svf_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Restart leaves two invalid samples
  sequence s_quiet2;
    !FREQ_VALID ##1 !FREQ_VALID;
  endsequence
  property p_width; FREQ_OUT |=> !FREQ_OUT; endproperty
  a_width: assert property (p_width) else $error("pulse too wide");
  property p_gap; FREQ_OUT && FREQ_VALID |-> ##[1:22] (FREQ_OUT || !FREQ_VALID); endproperty
  a_gap: assert property (p_gap) else $error("pulse gap too long");
  property p_halt; !POWER_DOWN_N |=> !FREQ_OUT && !FREQ_VALID; endproperty
  a_halt: assert property (p_halt) else $error("output in power-down");
  property p_resume; $rose(POWER_DOWN_N) |-> s_quiet2; endproperty
  a_resume: assert property (p_resume) else $error("valid too early on resume");
  property p_cfg; $changed(CFG) |=> !FREQ_VALID; endproperty
  a_cfg: assert property (p_cfg) else $error("valid kept over strap change");
  property p_multi; $rose(FREQ_VALID) && !CFG.single_variant |-> !$past(FREQ_VALID, 2); endproperty
  a_multi: assert property (p_multi) else $error("multi settle too short");
  property p_single; $rose(FREQ_VALID) && CFG.single_variant |-> !$past(FREQ_VALID, 8); endproperty
  a_single: assert property (p_single) else $error("single settle too short");
  property p_rst; disable iff (1'b0) SYS_RST |=> !FREQ_OUT && !FREQ_VALID; endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
endmodule
bind svf_converter svf_converter_properties svf_converter_properties_inst (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .CFG(CFG), .POWER_DOWN_N(POWER_DOWN_N), .FREQ_OUT(FREQ_OUT), .FREQ_VALID(FREQ_VALID));

//--- tb/svf_counter.sv
`timescale 1ns/100ps
module svf_counter (
  // Clock and pulse train
  input wire logic mclk,
  input wire logic freq_out,
  input wire logic freq_valid,
  // Gate and tally
  input wire logic gate,
  output int count
);
  // Unsettled pulses are not trusted, so they are dropped
  always_ff @(posedge mclk) begin
    if (!gate)
      count <= 0;
    else if (freq_out && freq_valid)
      count <= count + 1;
  end
endmodule

//--- tb/svf_converter_test.sv
`timescale 1ns/100ps
module svf_converter_test;
  import svf_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic pd_n = 1'b1;
  logic gate = 1'b0;
  svf_cfg_t cfg = '0;
  svf_ain_t ain = '0;
  logic [11:0] ref_level = 12'h400;
  logic freq_out;
  logic freq_valid;
  int count;
  int failures = 0;
  int compares = 0;
  // Free running clock
  always #10 mclk = ~mclk;
  svf_converter svf_converter_inst (.MCLK(mclk), .SYS_RST(sys_rst), .CFG(cfg), .POWER_DOWN_N(pd_n),
    .AIN(ain), .REF_LEVEL(ref_level), .FREQ_OUT(freq_out), .FREQ_VALID(freq_valid));
  svf_counter svf_counter_inst (.mclk(mclk), .freq_out(freq_out), .freq_valid(freq_valid), .gate(gate),
    .count(count));
  // Counts allow one pulse of gate phase error
  task automatic chk_cnt(string name, int exp, int got);
    compares++;
    if (got < exp - 1 || got > exp + 1) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic chk_bit(string name, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Settle, then count pulses over 200 clocks
  task automatic measure(string name, int exp);
    int i;
    i = 0;
    repeat (2) @(negedge mclk);
    while (freq_valid !== 1'b1 && i < 40) begin
      @(negedge mclk);
      i++;
    end
    chk_bit(name, 1'b1, freq_valid);
    gate = 1'b1;
    repeat (200) @(negedge mclk);
    chk_cnt(name, exp, count);
    gate = 1'b0;
  endtask
  task automatic t_channels();
    for (int k = 0; k < 4; k++) begin
      cfg = {1'b0, k[1:0], 2'b10};
      ain = {4{12'h100}};
      case (k)
        0, 3: ain.analog_input_one = 12'h500;
        1: ain.analog_input_two = 12'h500;
        default: ain.analog_input_three = 12'h500;
      endcase
      measure("channel", 90);
    end
  endtask
  task automatic t_span();
    cfg = '0;
    ain = {4{12'h300}};
    measure("bipolar mid", 50);
    cfg.polarity_select = 1'b1;
    measure("zero scale", 10);
    cfg.gain_select = 1'b1;
    ain.analog_input_one = 12'h500;
    measure("gain two", 90);
  endtask
  task automatic t_single();
    cfg = 5'b10001;
    ain = '0;
    ain.analog_input_one = 12'h200;
    measure("single", 50);
  endtask
  task automatic t_power();
    pd_n = 1'b0;
    repeat (50) @(negedge mclk);
    chk_bit("power-down valid", 1'b0, freq_valid);
    pd_n = 1'b1;
    measure("resume", 50);
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    t_channels();
    t_span();
    t_single();
    t_power();
    stop_test();
  end
  // Watchdog well past the expected run
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
